/* File: common/wtd_cfg.svh */
// Constants for the wake-up timer, duty-cycle transmit and battery check block.
// Assumes inclusion by bare name from the package and the logic file.
`ifndef WTD_CFG_SVH
`define WTD_CFG_SVH
`define WTD_CLK_HZ 25000000
// Nominal 25 MHz clock cycles per 32.768 kHz tick, loaded into the RC trim at reset.
`define WTD_TICK_HZ 32768
`define WTD_TICK_DIV (`WTD_CLK_HZ / `WTD_TICK_HZ)
`define WTD_DIV_W 10
// Wake period = M * 4 * 2^R ticks of the 32.768 kHz clock.
`define WTD_BASE_TICKS 4
`define WTD_CNT_W 40
`define WTD_EXP_W 4
`define WTD_MULT_W 16
`define WTD_CALP_W 3
// Calibration interval in expiries: 2^(period+1).
`define WTD_CAL_BASE_SH 1
// Calibration takes this many system cycles with the crystal running.
`define WTD_CAL_CYCLES 16
`define WTD_CALC_W 5
// Threshold code: 1.5 V + 50 mV * code, code 0..31 gives 1.5 .. 3.05 V, in mV.
`define WTD_LBD_MIN_MV 1500
`define WTD_LBD_STEP_MV 50
`define WTD_MV_W 12
`define WTD_THR_W 5
`define WTD_TX_TIMEOUT 8'hFF
`endif

/* File: common/wtd_pkg.sv */
// Types for the wake-up timer block.
// Assumes wtd_cfg.svh is on the include path.
`include "wtd_cfg.svh"
package wtd_pkg;
  typedef struct packed {
    logic timer_en;
    logic cal_en;
    logic [`WTD_CALP_W-1:0] cal_period;
    logic ldc_en;
    logic lbd_en;
    logic ext_xtal;
  } wtd_config_t;
  typedef struct packed {
    logic timer;
    logic lowbat;
    logic pkt_sent;
  } wtd_flags_t;
  typedef enum logic [2:0] {
    WTD_ST_CAL,
    WTD_ST_WAIT,
    WTD_ST_TX
  } wtd_state_t;
endpackage

/* File: logic/wtd_wake_timer.sv */
// Wake-up timer with periodic calibration, low-duty transmit and battery check.
// Assumes the 32 kHz sources arrive as pins and are synchronised here;
// shutdown_input is the asynchronous reset rst.
//
// Overview of operation
// (R1) Wake counter ticks from internal RC or external 32 kHz crystal, by config.
// (R2) With timer enabled, counter runs through the programmed period while asleep.
// (R3) Wake period is multiplier times 4 times 2^exponent 32 kHz ticks.
// (R4) Each expiry sets the timer event; interrupt pin falls if enabled.
// (R5) Host confirms the event by reading the interrupt status.
// (R6) RC is calibrated at power-up and on leaving shutdown.
// (R7) Periodic recalibration only with calibration enabled, interval from 3-bit field.
// (R8) Calibration runs the crystal and measures RC against it, then trims; here RC is timed in system clock cycles.
// (R9) Host should pick long calibration periods to save current.
// (R10) Low-duty transmit uses the wake timer, enabled in timer config.
// (R11) Duty period is duty count times 4 times 2^exponent ticks.
// (R12) Duty mode wakes to send buffered packet; packet_done_event raises interrupt if enabled.
// (R13) After each transmission, return to timer wait until next wake.
// (R14) Battery check enabled in timer config, only while timer enabled.
// (R15) Each expiry with battery check compares battery against threshold.
// (R16) Threshold is 1.5 V plus 50 mV steps up to 3.05 V.
// (R17) Low battery reported by interrupt or on a general purpose pin.
// (R18) Host may request a converter battery reading anytime.
// (R19) Shutdown resets timer and all settings; here the settings are input ports, which rst does not clear.
// (R20) Counter reloads after each expiry and repeats until disabled.
// (R21) Flags stay pending, holding interrupt low, until status is read.
`timescale 1ns/10ps
`include "wtd_cfg.svh"
module wtd_wake_timer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire wtd_pkg::wtd_config_t wake_timer_config,
  input wire logic [`WTD_EXP_W-1:0] wake_exponent_setting,
  input wire logic [`WTD_MULT_W-1:0] wake_multiplier_setting,
  input wire logic [`WTD_MULT_W-1:0] duty_period_setting,
  input wire logic [`WTD_THR_W-1:0] battery_threshold_setting,
  input wire wtd_pkg::wtd_flags_t chip_interrupt_enable,
  input wire logic lbd_irq_mode,
  input wire logic rc_clk_pin,
  input wire logic xtal32_clk_pin,
  input wire logic [`WTD_MV_W-1:0] battery_mv,
  input wire logic power_up_cmd,
  input wire logic read_interrupt_status_cmd,
  input wire logic converter_read_command,
  input wire logic tx_done,
  output logic interrupt_out_n,
  output wtd_pkg::wtd_flags_t int_status,
  output logic lbd_gpio,
  output logic tx_start,
  output logic xtal_on,
  output logic cal_busy,
  output logic [`WTD_MV_W-1:0] converter_value,
  output logic converter_valid,
  output logic [`WTD_DIV_W-1:0] rc_trim
);
  // ==========================================================================
  // Source selection and synchronisation
  logic [2:0] rc_sync_reg;
  logic [2:0] xt_sync_reg;
  logic src_level_reg;
  logic rc_level_reg;
  // Only the last two stages of each chain are read, so a metastable first stage never leaks.
  wire rc_agree = (rc_sync_reg[2] == rc_sync_reg[1]);
  wire xt_agree = (xt_sync_reg[2] == xt_sync_reg[1]);
  wire src_now = wake_timer_config.ext_xtal ? xt_sync_reg[2] : rc_sync_reg[2];
  wire src_agree = wake_timer_config.ext_xtal ? xt_agree : rc_agree;
  wire tick = src_agree && src_now && !src_level_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rc_sync_reg <= 3'h0;
    end else begin
      rc_sync_reg <= {rc_sync_reg[1:0], rc_clk_pin};
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      xt_sync_reg <= 3'h0;
    end else begin
      xt_sync_reg <= {xt_sync_reg[1:0], xtal32_clk_pin};
    end
  end
  // The accepted level follows the selected source; a change of source may cost one tick.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      src_level_reg <= 1'b0;
    end else if (src_agree) begin
      src_level_reg <= src_now; // R1
    end
  end
  // The RC level is kept apart so calibration sees RC edges whichever source is selected.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rc_level_reg <= 1'b0;
    end else if (rc_agree) begin
      rc_level_reg <= rc_sync_reg[2]; // R8
    end
  end

  // ==========================================================================
  // Period counters
  wire [`WTD_CNT_W-1:0] wake_len =
    ({24'h0, wake_multiplier_setting} * `WTD_CNT_W'(`WTD_BASE_TICKS)) << wake_exponent_setting; // R3
  wire [`WTD_CNT_W-1:0] duty_len =
    ({24'h0, duty_period_setting} * `WTD_CNT_W'(`WTD_BASE_TICKS)) << wake_exponent_setting; // R11
  logic [`WTD_CNT_W-1:0] wake_cnt_reg;
  logic [`WTD_CNT_W-1:0] duty_cnt_reg;
  wire timer_on = wake_timer_config.timer_en; // R2
  wire wake_hit = timer_on && tick && (wake_cnt_reg + `WTD_CNT_W'(1) >= wake_len);
  wire duty_on = timer_on && wake_timer_config.ldc_en; // R10
  wire duty_hit = duty_on && tick && (duty_cnt_reg + `WTD_CNT_W'(1) >= duty_len);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_cnt_reg <= `WTD_CNT_W'h0;
      duty_cnt_reg <= `WTD_CNT_W'h0;
    end else begin
      if (!timer_on || wake_hit) begin
        wake_cnt_reg <= `WTD_CNT_W'h0; // R20
      end else if (tick) begin
        wake_cnt_reg <= wake_cnt_reg + `WTD_CNT_W'(1); // R2
      end
      if (!duty_on || duty_hit) begin
        duty_cnt_reg <= `WTD_CNT_W'h0; // R20
      end else if (tick) begin
        duty_cnt_reg <= duty_cnt_reg + `WTD_CNT_W'(1);
      end
    end
  end

  // ==========================================================================
  // Calibration and transmit sequencing
  wtd_pkg::wtd_state_t state_reg;
  wtd_pkg::wtd_state_t state_next;
  logic [`WTD_CALC_W-1:0] cal_cnt_reg;
  logic [7:0] cal_exp_reg;
  logic [`WTD_DIV_W-1:0] meas_reg;
  logic [7:0] tx_wait_reg;
  logic cal_req_reg;
  wire st_cal = (state_reg == wtd_pkg::WTD_ST_CAL);
  wire st_wait = (state_reg == wtd_pkg::WTD_ST_WAIT);
  wire st_tx = (state_reg == wtd_pkg::WTD_ST_TX);
  wire [2:0] cal_period_sh = wake_timer_config.cal_period;
  // Nine bits so that the longest interval, 256 expiries, does not wrap to zero.
  wire [8:0] cal_every = 9'h1 << (4'(cal_period_sh) + 4'(`WTD_CAL_BASE_SH));
  wire [8:0] cal_exp_inc = {1'b0, cal_exp_reg} + 9'h1;
  wire cal_due = wake_timer_config.cal_en && wake_hit && (cal_exp_inc >= cal_every); // R7
  wire cal_done = (state_reg == wtd_pkg::WTD_ST_CAL) &&
                  (cal_cnt_reg == `WTD_CALC_W'(`WTD_CAL_CYCLES - 1));
  wire tx_end = (state_reg == wtd_pkg::WTD_ST_TX) && (tx_done || tx_wait_reg == `WTD_TX_TIMEOUT);
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      wtd_pkg::WTD_ST_CAL: begin
        if (cal_done) begin
          state_next = wtd_pkg::WTD_ST_WAIT;
        end
      end
      wtd_pkg::WTD_ST_WAIT: begin
        if (power_up_cmd || cal_req_reg) begin
          state_next = wtd_pkg::WTD_ST_CAL; // R6
        end else if (duty_hit) begin
          state_next = wtd_pkg::WTD_ST_TX; // R12
        end
      end
      wtd_pkg::WTD_ST_TX: begin
        if (tx_end) begin
          state_next = wtd_pkg::WTD_ST_WAIT; // R13
        end
      end
      default: state_next = wtd_pkg::WTD_ST_WAIT;
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= wtd_pkg::WTD_ST_CAL; // R6
      cal_cnt_reg <= `WTD_CALC_W'h0;
      tx_wait_reg <= 8'h0;
    end else begin
      state_reg <= state_next;
      cal_cnt_reg <= st_cal ? cal_cnt_reg + `WTD_CALC_W'(1) : `WTD_CALC_W'h0;
      tx_wait_reg <= st_tx ? tx_wait_reg + 8'h1 : 8'h0;
    end
  end
  // Expiries are counted only while recalibration is enabled, so enabling it starts afresh.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cal_exp_reg <= 8'h0;
    end else if (cal_due || !wake_timer_config.cal_en) begin
      cal_exp_reg <= 8'h0;
    end else if (wake_hit) begin
      cal_exp_reg <= cal_exp_reg + 8'h1;
    end
  end
  // A request raised during a transmit waits until the state machine is back in wait.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cal_req_reg <= 1'b0;
    end else if (cal_due) begin
      cal_req_reg <= 1'b1; // R7
    end else if (st_cal) begin
      cal_req_reg <= 1'b0;
    end
  end

  // System clock cycles between RC rising edges set the trim; the crystal only runs while calibrating.
  logic [`WTD_DIV_W-1:0] edge_cnt_reg;
  wire rc_edge = rc_sync_reg[2] && rc_agree && !rc_level_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      edge_cnt_reg <= `WTD_DIV_W'h0;
      meas_reg <= `WTD_DIV_W'(`WTD_TICK_DIV);
    end else if (state_reg == wtd_pkg::WTD_ST_CAL) begin
      edge_cnt_reg <= rc_edge ? `WTD_DIV_W'h0 : edge_cnt_reg + `WTD_DIV_W'(1); // R8
      if (rc_edge && edge_cnt_reg != `WTD_DIV_W'h0) begin
        meas_reg <= edge_cnt_reg; // R8
      end
    end else begin
      edge_cnt_reg <= `WTD_DIV_W'h0;
    end
  end

  // ==========================================================================
  // Battery check and converter
  wire lbd_on = timer_on && wake_timer_config.lbd_en; // R14
  wire [`WTD_MV_W-1:0] thr_mv = `WTD_MV_W'(`WTD_LBD_MIN_MV) +
    `WTD_MV_W'(battery_threshold_setting) * `WTD_MV_W'(`WTD_LBD_STEP_MV); // R16
  // Strictly below the threshold counts as low; equal to it is still good.
  wire below_thr = (battery_mv < thr_mv);
  wire lbd_check = lbd_on && wake_hit; // R15
  wire low_now = lbd_check && below_thr; // R15
  wire ok_now = lbd_check && !below_thr;

  // ==========================================================================
  // Status flags and outputs; an event in the read cycle survives the clear.
  wtd_pkg::wtd_flags_t set_now;
  assign set_now = '{timer: wake_hit,
                     lowbat: low_now && lbd_irq_mode,
                     pkt_sent: tx_end && tx_done};
  wire [2:0] pend = int_status & chip_interrupt_enable;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      int_status <= '0; // R19
    end else begin
      int_status <= set_now | (read_interrupt_status_cmd ? 3'h0 : int_status); // R21 R4 R12 R5
    end
  end
  // The pin follows the registered flags, so it lags a new event by one cycle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= ~|pend; // R4 R21
    end
  end
  // The pin result is a level that tracks the latest comparison, not a sticky flag.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lbd_gpio <= 1'b0;
    end else if (low_now && !lbd_irq_mode) begin
      lbd_gpio <= 1'b1; // R17
    end else if (ok_now || !lbd_on) begin
      lbd_gpio <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_start <= 1'b0;
    end else begin
      tx_start <= duty_hit && st_wait; // R12
    end
  end
  // The crystal runs only while calibrating, since it dominates the sleep current.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      xtal_on <= 1'b1;
    end else begin
      xtal_on <= (state_next == wtd_pkg::WTD_ST_CAL); // R8
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cal_busy <= 1'b1;
    end else begin
      cal_busy <= (state_next == wtd_pkg::WTD_ST_CAL);
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      converter_valid <= 1'b0;
    end else begin
      converter_valid <= converter_read_command; // R18
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      converter_value <= `WTD_MV_W'h0;
    end else if (converter_read_command) begin
      converter_value <= battery_mv; // R18
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rc_trim <= `WTD_DIV_W'(`WTD_TICK_DIV);
    end else if (cal_done) begin
      rc_trim <= meas_reg; // R8
    end
  end
endmodule

/* File: tb/wtd_far_model.sv */
// Far-side model: the two 32 kHz clock sources and the packet sender.
// Assumes one system clock; the sources are slowed to HALF cycles per level.
`timescale 1ns/10ps
module wtd_far_model #(
  parameter int HALF = 8,
  parameter int TX_LAT = 5
) (
  input wire logic clk_sys,
  input wire logic rc_run,
  input wire logic xt_run,
  input wire logic tx_start,
  output logic rc_clk_pin,
  output logic xtal32_clk_pin,
  output logic tx_done
);
  // ==========================================
  // Sources and sender
  int ph = 0;
  int txc = 0;
  initial begin
    rc_clk_pin = 1'b0;
    xtal32_clk_pin = 1'b0;
    tx_done = 1'b0;
  end
  // A stopped source holds its level, as an oscillator that is switched off.
  always @(posedge clk_sys) begin
    ph <= (ph == HALF - 1) ? 0 : ph + 1;
    if (ph == HALF - 1) begin
      rc_clk_pin <= rc_run ? ~rc_clk_pin : rc_clk_pin;
      xtal32_clk_pin <= xt_run ? ~xtal32_clk_pin : xtal32_clk_pin;
    end
    tx_done <= (txc == 1);
    txc <= tx_start ? TX_LAT : ((txc > 0) ? txc - 1 : 0);
  end
endmodule

/* File: tb/wtd_wake_timer_properties.sv */
// Port-level checker for the wake-up timer block.
// Assumes it is bound to every instance of the timer block.
`timescale 1ns/10ps
`include "wtd_cfg.svh"
module wtd_wake_timer_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire wtd_pkg::wtd_config_t wake_timer_config,
  input wire wtd_pkg::wtd_flags_t chip_interrupt_enable,
  input wire logic [`WTD_MV_W-1:0] battery_mv,
  input wire logic power_up_cmd,
  input wire logic read_interrupt_status_cmd,
  input wire logic converter_read_command,
  input wire logic tx_done,
  input wire logic interrupt_out_n,
  input wire wtd_pkg::wtd_flags_t int_status,
  input wire logic tx_start,
  input wire logic xtal_on,
  input wire logic cal_busy,
  input wire logic [`WTD_MV_W-1:0] converter_value,
  input wire logic converter_valid
);
  // ==========================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire pend = |(int_status & chip_interrupt_enable);
  sequence s_cal;
    (cal_busy && xtal_on)[*8] ##[7:10] !cal_busy;
  endsequence
  sequence s_conv;
    converter_valid && (converter_value == $past(battery_mv));
  endsequence
  AST_IRQ_SET: assert property (pend |=> !interrupt_out_n)
    else $error("interrupt line high while an enabled event is pending");
  AST_IRQ_CLR: assert property (!pend |=> interrupt_out_n)
    else $error("interrupt line low with nothing pending");
  AST_STICKY: assert property (int_status.timer && !read_interrupt_status_cmd |=> int_status.timer)
    else $error("timer flag dropped without a status read");
  AST_TMR_EN: assert property ($rose(int_status.timer) |-> $past(wake_timer_config.timer_en))
    else $error("timer event while the timer is disabled");
  AST_LBD_EN: assert property ($rose(int_status.lowbat) |->
    $past(wake_timer_config.lbd_en) && $past(wake_timer_config.timer_en))
    else $error("battery event without timer and battery check enabled");
  AST_CAL_SRC: assert property ($rose(cal_busy) |-> wake_timer_config.cal_en ||
    $past(power_up_cmd) || $past(power_up_cmd, 2))
    else $error("calibration started without a cause");
  AST_CAL_RUN: assert property ($rose(cal_busy) |-> s_cal)
    else $error("calibration length or crystal enable wrong");
  AST_CONV: assert property (converter_read_command |=> s_conv)
    else $error("converter reading missing or wrong");
  AST_TX_ONE: assert property (tx_start |-> $past(wake_timer_config.ldc_en) ##1 !tx_start)
    else $error("transmit start outside duty mode or too long");
  AST_PKT: assert property ($rose(int_status.pkt_sent) |-> $past(tx_done))
    else $error("packet flag without a finished packet");
endmodule
bind wtd_wake_timer wtd_wake_timer_properties u_props (
  .clk_sys(clk_sys), .rst(rst), .wake_timer_config(wake_timer_config),
  .chip_interrupt_enable(chip_interrupt_enable), .battery_mv(battery_mv),
  .power_up_cmd(power_up_cmd), .read_interrupt_status_cmd(read_interrupt_status_cmd),
  .converter_read_command(converter_read_command), .tx_done(tx_done),
  .interrupt_out_n(interrupt_out_n), .int_status(int_status), .tx_start(tx_start),
  .xtal_on(xtal_on), .cal_busy(cal_busy), .converter_value(converter_value),
  .converter_valid(converter_valid)
);

/* File: tb/testbench.sv */
// Self-checking bench: period, masking, source select, duty transmit, battery check.
// Assumes the far model supplies the clock pins and answers each transmit start.
`timescale 1ns/10ps
`include "wtd_cfg.svh"
module testbench;
  logic clk_sys, rst, irq_mode, pwr_cmd, rd_cmd, conv_cmd, rc_run, xt_run, tx_done;
  logic irq_n, lbd_gpio, tx_start, xtal_on, cal_busy, conv_valid, rc_pin, xt_pin;
  wtd_pkg::wtd_config_t cfg;
  wtd_pkg::wtd_flags_t ien, int_status;
  logic [`WTD_EXP_W-1:0] r_set = 4'h1;
  logic [`WTD_MULT_W-1:0] m_set = 16'h0003;
  logic [`WTD_MULT_W-1:0] d_set = 16'h0002;
  logic [`WTD_THR_W-1:0] thr = 5'h1F;
  logic [`WTD_MV_W-1:0] bat = 12'hBB8;
  logic [`WTD_MV_W-1:0] conv_val;
  logic [`WTD_DIV_W-1:0] trim;
  int err_total = 0, num_checks = 0, cyc = 0, t0, c;
  wire [6:0] obs = {~cal_busy, cal_busy, lbd_gpio, tx_start, int_status};
  wtd_wake_timer dut (.clk_sys(clk_sys), .rst(rst), .wake_timer_config(cfg),
    .wake_exponent_setting(r_set), .wake_multiplier_setting(m_set),
    .duty_period_setting(d_set), .battery_threshold_setting(thr),
    .chip_interrupt_enable(ien), .lbd_irq_mode(irq_mode), .rc_clk_pin(rc_pin),
    .xtal32_clk_pin(xt_pin), .battery_mv(bat), .power_up_cmd(pwr_cmd),
    .read_interrupt_status_cmd(rd_cmd), .converter_read_command(conv_cmd),
    .tx_done(tx_done), .interrupt_out_n(irq_n), .int_status(int_status),
    .lbd_gpio(lbd_gpio), .tx_start(tx_start), .xtal_on(xtal_on), .cal_busy(cal_busy),
    .converter_value(conv_val), .converter_valid(conv_valid), .rc_trim(trim));
  wtd_far_model far (.clk_sys(clk_sys), .rc_run(rc_run), .xt_run(xt_run),
    .tx_start(tx_start), .rc_clk_pin(rc_pin), .xtal32_clk_pin(xt_pin), .tx_done(tx_done));
  // ==========================================
  // Tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t mismatch got %0h expected %0h", $time, got, exp);
    end
  endtask
  task wt(input int b, input int lim);
    c = 0;
    do begin
      @(posedge clk_sys);
      #1 c++;
    end while (obs[b] !== 1'b1 && c < lim);
  endtask
  task rd;
    @(posedge clk_sys) rd_cmd <= 1'b1;
    @(posedge clk_sys) rd_cmd <= 1'b0;
    #1;
  endtask
  task finish_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // Clock, timeout and tests
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Whole sequence needs under 10000 cycles; the margin covers slow calibration.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    rst = 1'b1;
    cfg = '0;
    ien = '0;
    {irq_mode, pwr_cmd, rd_cmd, conv_cmd, rc_run, xt_run} = '0;
    repeat (10) @(posedge clk_sys);
    #1 chk({irq_n, cal_busy, xtal_on, int_status}, 16'h0038);
    @(posedge clk_sys) rst <= 1'b0;
    wt(6, 40);
    chk(obs[6], 16'h0001);
    $display("test 1 done");
    @(posedge clk_sys) begin cfg.timer_en <= 1'b1; ien <= 3'h7; rc_run <= 1'b1; end
    wt(2, 1000);
    @(posedge clk_sys);
    #1 chk(irq_n, 16'h0000);
    rd();
    repeat (2) @(posedge clk_sys);
    #1 chk(irq_n, 16'h0001);
    wt(2, 1000);
    t0 = cyc;
    rd();
    wt(2, 1000);
    chk(16'(cyc - t0), 16'h0180);
    rd();
    @(posedge clk_sys) ien.timer <= 1'b0;
    wt(2, 1000);
    repeat (2) @(posedge clk_sys);
    #1 chk(irq_n, 16'h0001);
    $display("test 2 done");
    @(posedge clk_sys) begin cfg.ext_xtal <= 1'b1; rc_run <= 1'b0; xt_run <= 1'b1; end
    rd();
    wt(2, 1000);
    chk(obs[2], 16'h0001);
    $display("test 3 done");
    @(posedge clk_sys) cfg.ldc_en <= 1'b1;
    wt(3, 1000);
    t0 = cyc;
    wt(0, 300);
    chk(obs[0], 16'h0001);
    rd();
    wt(3, 1000);
    chk(16'(cyc - t0), 16'h0100);
    @(posedge clk_sys) begin cfg.ldc_en <= 1'b0; cfg.lbd_en <= 1'b1; irq_mode <= 1'b1; end
    $display("test 4 done");
    rd();
    wt(2, 1000);
    @(posedge clk_sys);
    #1 chk(obs[1], 16'h0001);
    @(posedge clk_sys) thr <= 5'h1E;
    rd();
    wt(2, 1000);
    @(posedge clk_sys);
    #1 chk(obs[1], 16'h0000);
    @(posedge clk_sys) begin thr <= 5'h1F; irq_mode <= 1'b0; end
    wt(4, 1000);
    chk(obs[4], 16'h0001);
    $display("test 5 done");
    @(posedge clk_sys) begin bat <= 12'hABC; conv_cmd <= 1'b1; end
    @(posedge clk_sys) conv_cmd <= 1'b0;
    #1 chk({conv_valid, conv_val}, 16'h1ABC);
    @(posedge clk_sys) pwr_cmd <= 1'b1;
    @(posedge clk_sys) pwr_cmd <= 1'b0;
    wt(5, 4);
    chk({obs[5], xtal_on}, 16'h0003);
    wt(6, 40);
    // Longest interval would waste run time; interval code 0 recalibrates every 2 expiries.
    @(posedge clk_sys) begin cfg.cal_en <= 1'b1; cfg.cal_period <= 3'h0; end
    wt(5, 2000);
    chk(obs[5], 16'h0001);
    chk(16'(trim), 16'(`WTD_TICK_DIV));
    $display("test 6 done");
    finish_test();
  end
endmodule
